/* ssrp_host.sv */
`timescale 1ns/1ps
module ssrp_host #(
    parameter int H = 12
) (
    // system clock and wire level
    input wire logic mclk_i,
    input wire logic sda_i,
    // pins toward the device
    output logic scl_o,
    output logic sda_o,
    output logic fw_sclk_o,
    output logic cs_n_o
);
    logic fw_run = 1'b0;
    ////////////////////////////////////////
    // idle bus, link clock only within frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        cs_n_o = 1'b1;
        fw_sclk_o = 1'b0;
        #0.5;
        forever #3 fw_sclk_o = fw_run & ~fw_sclk_o;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // one bit: data set while clock low, sampled at end of high
    task automatic bitx(input logic b, output logic r);
        tick(6);
        sda_o <= b;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    // start or repeated start
    task automatic start();
        tick(6);
        sda_o <= 1'b1;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        sda_o <= 1'b0;
        tick(H);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick(6);
        sda_o <= 1'b0;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        sda_o <= 1'b1;
        tick(H);
    endtask
    // byte out msb first, wire released for the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic ack_me, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!ack_me, r);
    endtask
    // three-wire bits msb first, one link clock edge per bit, edges spaced to stay at or below 10 MHz
    task automatic fw_bits(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            sda_o <= v[i];
            fw_run = 1'b1;
            @(posedge fw_sclk_o);
            fw_run = 1'b0;
            #100;
        end
    endtask
    task automatic fw_frame(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1, input int nb);
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        #1;
        fw_run = 1'b1;
        fw_bits(a, 16);
        fw_bits({8'h00, d0}, 8);
        if (nb > 1) begin
            fw_run = 1'b0;
            #400;
            fw_run = 1'b1;
            fw_bits({8'h00, d1}, 8);
        end
        fw_run = 1'b0;
        sda_o <= 1'b1;
        tick(10);
        cs_n_o <= 1'b1;
    endtask
    task automatic hold_sel(input logic v);
        @(posedge mclk_i);
        cs_n_o <= v;
        tick(8);
    endtask
endmodule

/* ssrp_pkg.sv */
package ssrp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // two-wire slave addresses (7-bit form of the write/read address pair)
    localparam logic [6:0] PRI_ADDR7 = 7'h36; // write 0x6c, read 0x6d
    localparam logic [6:0] SEC_ADDR7 = 7'h37; // write 0x6e, read 0x6f

    // serial framing
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] FW_ADDR_LAST_BIT = 5'h0f;
    localparam logic [4:0] FW_BYTE_LAST_BIT = 5'h07;

    ////////////////////////////////////////////////////////////////////////
    // address space regions and fixed locations
    localparam logic [15:0] ID_ADDR_HI = 16'h0000;
    localparam logic [15:0] ID_ADDR_LO = 16'h0001;
    localparam logic [15:0] MODE_ADDR = 16'h0100;
    localparam logic [15:0] CFG_STORE_TOP = 16'h03ff;
    localparam logic [15:0] CFG_REGION_TOP = 16'h0fff;
    localparam logic [15:0] LIM_REGION_BASE = 16'h1000;
    localparam logic [15:0] LIM_REGION_TOP = 16'h1fff;
    localparam logic [15:0] VND_REGION_BASE = 16'h3000;
    localparam logic [15:0] VND_STORE_TOP = 16'h30ff;
    localparam logic [15:0] COARSE_CFG_ADDR = 16'h0202;
    localparam logic [15:0] COARSE_VND_ADDR = 16'h3012;
    localparam logic [15:0] VND_CTRL_LO_ADDR = 16'h301b;

    // field positions
    localparam int MODE_STREAM_BIT = 0;
    localparam int VND_STREAM_BIT = 2;

    // reset values
    localparam logic [7:0] MEM_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic STREAM_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // synchronised pin vector layout and idle levels
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_CS_N = 2;
    localparam int PIN_PAD = 3;
    localparam int PIN_ALT_EN = 4;
    localparam int PIN_MOBILE = 5;
    localparam int PIN_FW_EN = 6;
    localparam int PIN_COUNT = 7;
    localparam logic [6:0] PIN_RST = 7'h07;

    // decoded kind of a register address
    typedef enum {
        K_NONE,
        K_ID,
        K_MODE,
        K_CFG,
        K_VND,
        K_LIM
    } ssrp_kind_t;

endpackage

/* ssrp_port.sv */
`timescale 1ns/1ps
module ssrp_port #(
    parameter logic [15:0] PART_ID = 16'h5a01 // arbitrary neutral value
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // two-wire serial bus
    input wire logic SERIAL_CLOCK_I,
    input wire logic SERIAL_DATA_I,
    output logic SERIAL_DATA_O,
    output logic SERIAL_DATA_OE_N_O,
    // three-wire fast-write port
    input wire logic FW_SCLK_I,
    input wire logic FW_CS_N_I,
    input wire logic FW_ENABLE_I,
    // address selection straps
    input wire logic ALT_ADDRESS_SELECT_I,
    input wire logic GENERAL_INPUT_PAD_I,
    input wire logic MOBILE_VARIANT_I,
    // status
    output logic STREAM_O,
    output logic [15:0] REG_PTR_O
);

    typedef enum {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK
    } ssrp_state_t;

    typedef enum {
        PH_ADDR,
        PH_PTR_HI,
        PH_PTR_LO,
        PH_DATA
    } ssrp_phase_t;

    ////////////////////////////////////////////////////////////////////////
    // address decode, used by both the write and the read path
    function automatic ssrp_pkg::ssrp_kind_t kind_of(input logic [15:0] a);
        if (a == ssrp_pkg::ID_ADDR_HI || a == ssrp_pkg::ID_ADDR_LO) begin
            kind_of = ssrp_pkg::K_ID;
        end else if (a == ssrp_pkg::MODE_ADDR) begin
            kind_of = ssrp_pkg::K_MODE;
        end else if (a <= ssrp_pkg::CFG_STORE_TOP) begin
            kind_of = ssrp_pkg::K_CFG;
        end else if (a <= ssrp_pkg::CFG_REGION_TOP) begin
            kind_of = ssrp_pkg::K_NONE;
        end else if (a >= ssrp_pkg::LIM_REGION_BASE && a <= ssrp_pkg::LIM_REGION_TOP) begin
            kind_of = ssrp_pkg::K_LIM;
        end else if (a[15:1] == ssrp_pkg::COARSE_VND_ADDR[15:1]) begin
            kind_of = ssrp_pkg::K_CFG; // vendor alias of the coarse exposure pair
        end else if (a >= ssrp_pkg::VND_REGION_BASE && a <= ssrp_pkg::VND_STORE_TOP) begin
            kind_of = ssrp_pkg::K_VND;
        end else begin
            kind_of = ssrp_pkg::K_NONE; // statistics region and gaps
        end
    endfunction

    // configuration storage index, folding the vendor alias onto its home
    function automatic logic [9:0] cfg_index(input logic [15:0] a);
        if (a[15:1] == ssrp_pkg::COARSE_VND_ADDR[15:1]) begin
            cfg_index = {ssrp_pkg::COARSE_CFG_ADDR[9:1], a[0]};
        end else begin
            cfg_index = a[9:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, a change counts once stages 2 and 3 agree
    logic [ssrp_pkg::PIN_COUNT-1:0] pin_raw;
    logic [ssrp_pkg::PIN_COUNT-1:0] pin_f;

    assign pin_raw = {FW_ENABLE_I, MOBILE_VARIANT_I, ALT_ADDRESS_SELECT_I, GENERAL_INPUT_PAD_I,
                      FW_CS_N_I, SERIAL_DATA_I, SERIAL_CLOCK_I};

    genvar gi;
    generate
        for (gi = 0; gi < ssrp_pkg::PIN_COUNT; gi++) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic f_ff;
            always_ff @(posedge MCLK_I or posedge RST_I) begin
                if (RST_I) begin
                    s1_ff <= ssrp_pkg::PIN_RST[gi];
                    s2_ff <= ssrp_pkg::PIN_RST[gi];
                    s3_ff <= ssrp_pkg::PIN_RST[gi];
                    f_ff <= ssrp_pkg::PIN_RST[gi];
                end else begin
                    s1_ff <= pin_raw[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        f_ff <= s3_ff;
                    end
                end
            end
            assign pin_f[gi] = f_ff;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // two-wire line events, blocked while the three-wire select is low
    logic scl_q_ff;
    logic sda_q_ff;
    logic tw_en;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic scl_f;
    logic sda_f;

    assign scl_f = pin_f[ssrp_pkg::PIN_SCL];
    assign sda_f = pin_f[ssrp_pkg::PIN_SDA];
    assign tw_en = pin_f[ssrp_pkg::PIN_CS_N];

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_f;
            sda_q_ff <= sda_f;
        end
    end

    assign scl_rise = tw_en & scl_f & ~scl_q_ff;
    assign scl_fall = tw_en & ~scl_f & scl_q_ff;
    assign start_ev = tw_en & scl_f & scl_q_ff & sda_q_ff & ~sda_f;
    assign stop_ev = tw_en & scl_f & scl_q_ff & ~sda_q_ff & sda_f;

    ////////////////////////////////////////////////////////////////////////
    // two-wire slave state
    ssrp_state_t state_ff;
    ssrp_phase_t phase_ff;
    logic [3:0] cnt_ff;
    logic [6:0] rx_sh_ff;
    logic [7:0] tx_sh_ff;
    logic rw_ff;
    logic drive_low_ff;
    logic [15:0] ptr_ff;
    logic [7:0] rx_byte;
    logic [6:0] own_addr7;
    logic byte_done;
    logic addr_hit;
    logic ptr_hi_ld;
    logic ptr_lo_ld;
    logic tw_wr;
    logic tx_load;
    logic [7:0] rd_byte;

    // own address: pair chosen by pad select, swapped on the mobile variant
    always_comb begin
        own_addr7 = ((pin_f[ssrp_pkg::PIN_ALT_EN] & pin_f[ssrp_pkg::PIN_PAD]) ^ pin_f[ssrp_pkg::PIN_MOBILE]) ?
                    ssrp_pkg::SEC_ADDR7 : ssrp_pkg::PRI_ADDR7;
    end

    // byte-level strobes
    assign rx_byte = {rx_sh_ff, sda_f};
    assign byte_done = (state_ff == ST_RX) & scl_rise & (cnt_ff == ssrp_pkg::BYTE_LAST_BIT);
    assign addr_hit = rx_byte[7:1] == own_addr7;
    assign ptr_hi_ld = byte_done & (phase_ff == PH_PTR_HI);
    assign ptr_lo_ld = byte_done & (phase_ff == PH_PTR_LO);
    assign tw_wr = byte_done & (phase_ff == PH_DATA);
    assign tx_load = scl_fall & (((state_ff == ST_ACK) & drive_low_ff & rw_ff) | (state_ff == ST_MACK));

    // protocol sequencer; the clock line is only ever sampled
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff <= ST_IDLE;
            phase_ff <= PH_ADDR;
            cnt_ff <= 4'h0;
            rx_sh_ff <= 7'h00;
            tx_sh_ff <= 8'h00;
            rw_ff <= 1'b0;
            drive_low_ff <= 1'b0;
        end else if (start_ev) begin
            state_ff <= ST_RX; // start or repeated start
            phase_ff <= PH_ADDR;
            cnt_ff <= 4'h0;
            drive_low_ff <= 1'b0;
        end else if (stop_ev) begin
            state_ff <= ST_IDLE;
            drive_low_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_RX: begin
                    if (scl_rise) begin
                        rx_sh_ff <= rx_byte[6:0];
                        cnt_ff <= cnt_ff + 4'h1;
                        if (byte_done) begin
                            case (phase_ff)
                                PH_ADDR: begin
                                    rw_ff <= rx_byte[0];
                                    phase_ff <= PH_PTR_HI;
                                    state_ff <= addr_hit ? ST_ACK : ST_IDLE;
                                end
                                PH_PTR_HI: begin
                                    phase_ff <= PH_PTR_LO;
                                    state_ff <= ST_ACK;
                                end
                                default: begin
                                    phase_ff <= PH_DATA;
                                    state_ff <= ST_ACK;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!drive_low_ff) begin
                            drive_low_ff <= 1'b1;
                        end else if (rw_ff) begin
                            state_ff <= ST_TX;
                            cnt_ff <= 4'h0;
                            tx_sh_ff <= rd_byte;
                            drive_low_ff <= ~rd_byte[7];
                        end else begin
                            state_ff <= ST_RX;
                            cnt_ff <= 4'h0;
                            drive_low_ff <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_ff == ssrp_pkg::BYTE_BITS) begin
                            state_ff <= ST_MACK;
                            drive_low_ff <= 1'b0;
                        end else begin
                            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                            drive_low_ff <= ~tx_sh_ff[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda_f) begin
                        state_ff <= ST_IDLE;
                    end else if (tx_load) begin
                        state_ff <= ST_TX;
                        cnt_ff <= 4'h0;
                        tx_sh_ff <= rd_byte;
                        drive_low_ff <= ~rd_byte[7];
                    end
                end
                default: begin
                    drive_low_ff <= 1'b0;
                end
            endcase
        end
    end

    // register pointer: loaded msb first, stepped after each byte
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            ptr_ff <= ssrp_pkg::PTR_RST;
        end else if (ptr_hi_ld) begin
            ptr_ff[15:8] <= rx_byte;
        end else if (ptr_lo_ld) begin
            ptr_ff[7:0] <= rx_byte;
        end else if (tw_wr || tx_load) begin
            ptr_ff <= ptr_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // three-wire link side; the bit assembly is held cleared while the select is high
    logic fw_rst;
    logic [4:0] fw_cnt_ff;
    logic [14:0] fw_sh_ff;
    logic [15:0] fw_addr_ff;
    logic fw_have_ff;
    logic [15:0] fw_out_addr_ff;
    logic [7:0] fw_out_data_ff;
    logic fw_tog_ff;

    assign fw_rst = RST_I | FW_CS_N_I;

    // bit assembly: 16 address bits, then data bytes, msb first
    always_ff @(posedge FW_SCLK_I or posedge fw_rst) begin
        if (fw_rst) begin
            fw_cnt_ff <= 5'h00;
            fw_sh_ff <= 15'h0000;
            fw_addr_ff <= 16'h0000;
            fw_have_ff <= 1'b0;
        end else begin
            fw_sh_ff <= {fw_sh_ff[13:0], SERIAL_DATA_I};
            fw_cnt_ff <= fw_cnt_ff + 5'h01;
            if (!fw_have_ff && fw_cnt_ff == ssrp_pkg::FW_ADDR_LAST_BIT) begin
                fw_addr_ff <= {fw_sh_ff, SERIAL_DATA_I};
                fw_have_ff <= 1'b1;
                fw_cnt_ff <= 5'h00;
            end else if (fw_have_ff && fw_cnt_ff == ssrp_pkg::FW_BYTE_LAST_BIT) begin
                fw_addr_ff <= fw_addr_ff + 16'h0001;
                fw_cnt_ff <= 5'h00;
            end
        end
    end

    // completed byte: word held stable, toggle announces it; survives frame end
    always_ff @(posedge FW_SCLK_I or posedge RST_I) begin
        if (RST_I) begin
            fw_out_addr_ff <= 16'h0000;
            fw_out_data_ff <= 8'h00;
            fw_tog_ff <= 1'b0;
        end else if (fw_have_ff && fw_cnt_ff == ssrp_pkg::FW_BYTE_LAST_BIT && !FW_CS_N_I) begin
            fw_out_addr_ff <= fw_addr_ff;
            fw_out_data_ff <= {fw_sh_ff[6:0], SERIAL_DATA_I};
            fw_tog_ff <= ~fw_tog_ff;
        end
    end

    // toggle crossing into the system clock
    logic tg1_ff;
    logic tg2_ff;
    logic tg3_ff;
    logic tg_seen_ff;
    logic fw_evt;

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            tg1_ff <= 1'b0;
            tg2_ff <= 1'b0;
            tg3_ff <= 1'b0;
            tg_seen_ff <= 1'b0;
        end else begin
            tg1_ff <= fw_tog_ff;
            tg2_ff <= tg1_ff;
            tg3_ff <= tg2_ff;
            if (tg2_ff == tg3_ff) begin
                tg_seen_ff <= tg3_ff;
            end
        end
    end

    assign fw_evt = (tg2_ff == tg3_ff) & (tg3_ff != tg_seen_ff) & pin_f[ssrp_pkg::PIN_FW_EN];

    ////////////////////////////////////////////////////////////////////////
    // single write port; three-wire bytes take precedence
    logic wr_en;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    ssrp_pkg::ssrp_kind_t wr_kind;
    ssrp_pkg::ssrp_kind_t rd_kind;

    always_comb begin
        wr_en = fw_evt | tw_wr;
        wr_addr = fw_evt ? fw_out_addr_ff : ptr_ff;
        wr_data = fw_evt ? fw_out_data_ff : rx_byte;
        wr_kind = kind_of(wr_addr);
        rd_kind = kind_of(ptr_ff);
    end

    // byte storage for configuration and vendor space
    logic [7:0] cfg_mem [0:1023];
    logic [7:0] vnd_mem [0:255];
    logic stream_ff;

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < 1024; i++) begin
                cfg_mem[i] <= ssrp_pkg::MEM_RST;
            end
            for (int j = 0; j < 256; j++) begin
                vnd_mem[j] <= ssrp_pkg::MEM_RST;
            end
        end else if (wr_en) begin
            if (wr_kind == ssrp_pkg::K_CFG) begin
                cfg_mem[cfg_index(wr_addr)] <= wr_data;
            end else if (wr_kind == ssrp_pkg::K_VND) begin
                vnd_mem[wr_addr[7:0]] <= wr_data;
            end
        end
    end

    // shared stream bit behind both of its addresses
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            stream_ff <= ssrp_pkg::STREAM_RST;
        end else if (wr_en && wr_kind == ssrp_pkg::K_MODE) begin
            stream_ff <= wr_data[ssrp_pkg::MODE_STREAM_BIT];
        end else if (wr_en && wr_addr == ssrp_pkg::VND_CTRL_LO_ADDR) begin
            stream_ff <= wr_data[ssrp_pkg::VND_STREAM_BIT];
        end
    end

    // read data at the pointer
    always_comb begin
        rd_byte = 8'h00;
        case (rd_kind)
            ssrp_pkg::K_ID: begin
                rd_byte = ptr_ff[0] ? PART_ID[7:0] : PART_ID[15:8];
            end
            ssrp_pkg::K_MODE: begin
                rd_byte[ssrp_pkg::MODE_STREAM_BIT] = stream_ff;
            end
            ssrp_pkg::K_CFG: begin
                rd_byte = cfg_mem[cfg_index(ptr_ff)];
            end
            ssrp_pkg::K_VND: begin
                rd_byte = vnd_mem[ptr_ff[7:0]];
                if (ptr_ff == ssrp_pkg::VND_CTRL_LO_ADDR) begin
                    rd_byte[ssrp_pkg::VND_STREAM_BIT] = stream_ff;
                end
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    logic sda_o_ff;
    logic oe_n_ff;

    // enable registered once more so the pin sees no gate after the flop
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            sda_o_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            sda_o_ff <= 1'b0; // open drain: only ever pulls low
            oe_n_ff <= ~drive_low_ff;
        end
    end

    assign SERIAL_DATA_O = sda_o_ff;
    assign SERIAL_DATA_OE_N_O = oe_n_ff;
    assign STREAM_O = stream_ff;
    assign REG_PTR_O = ptr_ff;

endmodule

/* ssrp_port_chk.sv */
`timescale 1ns/1ps
module ssrp_port_chk (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_I,
    // watched pins
    input wire logic SERIAL_CLOCK_I,
    input wire logic FW_CS_N_I,
    input wire logic SERIAL_DATA_O,
    input wire logic SERIAL_DATA_OE_N_O,
    input wire logic STREAM_O,
    input wire logic [15:0] REG_PTR_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////
    // data drive: open drain, moves only while clock low, holds for eight cycles after it starts
    a_drive_low_only: assert property (SERIAL_DATA_O == 1'b0) else $error("data out high");
    a_drive_scl_low: assert property ($changed(SERIAL_DATA_OE_N_O) |-> !SERIAL_CLOCK_I) else $error("drive moved");
    a_drive_holds: assert property ($fell(SERIAL_DATA_OE_N_O) |=> !SERIAL_DATA_OE_N_O [*8]) else $error("drive short");
    // select low silences the two-wire side
    a_sel_no_drive: assert property (!FW_CS_N_I [*6] |-> SERIAL_DATA_OE_N_O) else $error("drive in select");
    a_sel_ptr_hold: assert property (!FW_CS_N_I [*6] |-> $stable(REG_PTR_O)) else $error("pointer in select");
    // pointer moves by one or by one loaded byte, then holds for four cycles
    a_ptr_step: assert property ($changed(REG_PTR_O) |-> REG_PTR_O == $past(REG_PTR_O) + 16'h0001
        || REG_PTR_O[15:8] == $past(REG_PTR_O[15:8]) || REG_PTR_O[7:0] == $past(REG_PTR_O[7:0])) else $error("bad step");
    a_ptr_one_step: assert property ($changed(REG_PTR_O) |=> $stable(REG_PTR_O) [*4]) else $error("double step");
    // stream bit moves only with a write
    a_stream_src: assert property ($changed(STREAM_O) |-> !FW_CS_N_I || REG_PTR_O != $past(REG_PTR_O, 2))
        else $error("stream moved alone");
    c_ack: cover property ($fell(SERIAL_DATA_OE_N_O));
    c_stream: cover property ($rose(STREAM_O));
    c_ptr: cover property ($changed(REG_PTR_O));
endmodule

/* ssrp_port_tb.sv */
`timescale 1ns/1ps
module ssrp_port_tb;
    localparam logic [15:0] ID = 16'h3c96; // arbitrary part code
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic fw_en = 1'b0, alt_en = 1'b0, pad = 1'b0, mobile = 1'b0;
    wire scl, h_sda, fw_sclk, cs_n, sda_o, oe_n, stream, sda_w;
    wire [15:0] ptr;
    int failures = 0, checks = 0;
    ////////////////////////////////////////
    // clock, open-drain wire, host and device
    always #10 mclk = ~mclk;
    assign sda_w = h_sda & (oe_n | sda_o);
    ssrp_host u_host (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl), .sda_o(h_sda), .fw_sclk_o(fw_sclk), .cs_n_o(cs_n));
    ssrp_port #(.PART_ID(ID)) u_dut (.MCLK_I(mclk), .RST_I(rst), .SERIAL_CLOCK_I(scl), .SERIAL_DATA_I(sda_w),
        .SERIAL_DATA_O(sda_o), .SERIAL_DATA_OE_N_O(oe_n), .FW_SCLK_I(fw_sclk), .FW_CS_N_I(cs_n),
        .FW_ENABLE_I(fw_en), .ALT_ADDRESS_SELECT_I(alt_en), .GENERAL_INPUT_PAD_I(pad),
        .MOBILE_VARIANT_I(mobile), .STREAM_O(stream), .REG_PTR_O(ptr));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // dataless write that loads the pointer
    task automatic setp(input logic [15:0] a);
        logic k0, k1, k2;
        u_host.start();
        u_host.wbyte(8'h6c, k0);
        u_host.wbyte(a[15:8], k1);
        u_host.wbyte(a[7:0], k2);
        chk({k0, k1, k2}, 16'h0007);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] q[$]);
        logic k;
        setp(a);
        foreach (q[i]) begin
            u_host.wbyte(q[i], k);
            chk(k, 1'b1);
        end
        u_host.stop();
    endtask
    // read from a, or from the current pointer when cur is set
    task automatic rd(input logic [15:0] a, input logic cur, input logic [7:0] q[$]);
        logic k;
        logic [7:0] d;
        if (!cur) setp(a);
        u_host.start();
        u_host.wbyte(8'h6d, k);
        chk(k, 1'b1);
        foreach (q[i]) begin
            u_host.rbyte(i < q.size() - 1, d);
            chk(d, q[i]);
        end
        u_host.stop();
        chk(oe_n, 1'b1);
    endtask
    task automatic t_addr();
        logic k;
        logic [7:0] pri;
        for (int s = 0; s < 8; s++) begin
            @(posedge mclk);
            {mobile, alt_en, pad} <= s[2:0];
            repeat (8) @(posedge mclk);
            pri = ((alt_en & pad) ^ mobile) ? 8'h6e : 8'h6c;
            for (int w = 0; w < 2; w++) begin
                u_host.start();
                u_host.wbyte(w ? 8'h6e : 8'h6c, k);
                chk(k, (w ? 8'h6e : 8'h6c) == pri);
                u_host.stop();
            end
        end
        @(posedge mclk);
        {mobile, alt_en, pad} <= 3'h0;
        repeat (8) @(posedge mclk);
        $display("test addr done");
    endtask
    task automatic t_seq();
        wr(16'h3010, {8'ha1, 8'hb2, 8'hc3, 8'hd4});
        chk(ptr, 16'h3014);
        rd(16'h0202, 1'b0, {8'hc3, 8'hd4});
        rd(16'h0000, 1'b1, {8'h00});
        chk(ptr, 16'h0205);
        $display("test seq done");
    endtask
    task automatic t_map();
        logic [15:0] ad[4] = '{16'h0000, 16'h1000, 16'h2000, 16'h3100};
        foreach (ad[i]) begin
            wr(ad[i], {8'h55});
            rd(ad[i], 1'b0, {i ? 8'h00 : ID[15:8]});
        end
        rd(16'h0000, 1'b0, {ID[15:8], ID[7:0]});
        $display("test map done");
    endtask
    task automatic t_stream();
        wr(ssrp_pkg::MODE_ADDR, {8'h01});
        chk(stream, 1'b1);
        rd(ssrp_pkg::VND_CTRL_LO_ADDR, 1'b0, {8'h04});
        wr(ssrp_pkg::VND_CTRL_LO_ADDR, {8'hf0});
        chk(stream, 1'b0);
        rd(ssrp_pkg::MODE_ADDR, 1'b0, {8'h00});
        rd(ssrp_pkg::VND_CTRL_LO_ADDR, 1'b0, {8'hf0});
        $display("test stream done");
    endtask
    task automatic t_fw();
        logic k;
        for (int e = 1; e >= 0; e--) begin
            @(posedge mclk);
            fw_en <= e[0];
            repeat (8) @(posedge mclk);
            u_host.fw_frame(ssrp_pkg::MODE_ADDR, e[7:0], 8'h00, 1);
            chk(stream, 1'b1);
        end
        fw_en <= 1'b1;
        u_host.fw_frame(16'h3040, 8'h11, 8'h22, 2);
        rd(16'h3040, 1'b0, {8'h11, 8'h22});
        u_host.hold_sel(1'b0);
        u_host.start();
        u_host.wbyte(8'h6c, k);
        chk(k, 1'b0);
        u_host.stop();
        u_host.hold_sel(1'b1);
        $display("test fw done");
    endtask
    task automatic finish_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_addr();
        t_seq();
        t_map();
        t_stream();
        t_fw();
        finish_test();
    end
    // watchdog
    initial begin
        #1500000;
        failures++;
        finish_test();
    end
endmodule
bind ssrp_port ssrp_port_chk u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .SERIAL_CLOCK_I(SERIAL_CLOCK_I),
    .FW_CS_N_I(FW_CS_N_I), .SERIAL_DATA_O(SERIAL_DATA_O), .SERIAL_DATA_OE_N_O(SERIAL_DATA_OE_N_O),
    .STREAM_O(STREAM_O), .REG_PTR_O(REG_PTR_O));
